// ---- inc/ufr_pkg.sv ----
// Constants and types of the user fuse row and its decoded configuration.
// Assumes one clock domain shared with the programming command engine.
//
// Operation
// - Writing 00h to a fuse clears it to its programmed state.
// - A plain write of FFh leaves the fuse as it was.
// - Nineteen fuses, each at its own address in the row.
// - Every fuse reads FFh when unprogrammed.
// - Fuses 0 and 1 pick crystal, reserved, external clock or RC.
// - Fuses 2 and 3 pick the wake-up timeout per clock source.
// - Fuse 4 makes the reset pin reset (FFh) or general I/O (00h).
// - Fuse 5 enables (FFh) or disables (00h) the brown-out detector.
// - Fuse 6 disables (FFh) or enables (00h) the on-chip debugger.
// - Fuse 7 permits programming (FFh); 00h permits it at power-on only.
// - Fuses 8 to 15 form the eight-bit RC oscillator trim.
// - Fuse 16 blocks (FFh) or allows (00h) user signature programming.
// - Fuse 17 starts ports tristated (FFh) or quasi-bidirectional (00h).
// - Fuse 18 picks normal (FFh) or fast (00h) debug interface.
// - Clock source changes apply only at the next power-on reset.
// - Reset-pin and programming-enable changes apply at session end.
// - Opcodes F1h, E1h, 61h; address increments after each data byte.

`default_nettype none

package ufr_pkg;

    localparam int          FUSE_COUNT     = 19;
    localparam logic [7:0]  FUSE_ERASED    = 8'hFF;
    localparam logic [7:0]  FUSE_PROGRAMMED = 8'h00;

    localparam logic [4:0]  ADDR_CS0       = 5'h00;
    localparam logic [4:0]  ADDR_CS1       = 5'h01;
    localparam logic [4:0]  ADDR_STARTUP0   = 5'h02;
    localparam logic [4:0]  ADDR_STARTUP1   = 5'h03;
    localparam logic [4:0]  ADDR_RST_PIN    = 5'h04;
    localparam logic [4:0]  ADDR_BROWNOUT   = 5'h05;
    localparam logic [4:0]  ADDR_DEBUG      = 5'h06;
    localparam logic [4:0]  ADDR_PROG_EN    = 5'h07;
    localparam logic [4:0]  ADDR_TRIM_BASE  = 5'h08;
    localparam logic [4:0]  ADDR_SIG        = 5'h10;
    localparam logic [4:0]  ADDR_TRISTATE   = 5'h11;
    localparam logic [4:0]  ADDR_DEBUG_FAST = 5'h12;

    localparam logic [7:0]  OP_FUSE_WRITE    = 8'hE1;
    localparam logic [7:0]  OP_FUSE_WRITE_AE = 8'hF1;
    localparam logic [7:0]  OP_FUSE_READ     = 8'h61;

    // Wake-up timeouts in microseconds, indexed by the two start-up fuses.
    localparam logic [13:0] DELAY_CRYSTAL_US_0 = 14'h03E8;
    localparam logic [13:0] DELAY_CRYSTAL_US_1 = 14'h07D0;
    localparam logic [13:0] DELAY_CRYSTAL_US_2 = 14'h0FA0;
    localparam logic [13:0] DELAY_CRYSTAL_US_3 = 14'h3E80;
    localparam logic [13:0] DELAY_OTHER_US_0   = 14'h0010;
    localparam logic [13:0] DELAY_OTHER_US_1   = 14'h0200;
    localparam logic [13:0] DELAY_OTHER_US_2   = 14'h03E8;
    localparam logic [13:0] DELAY_OTHER_US_3   = 14'h0FA0;

    typedef enum logic [1:0] {
        UFR_CLK_CRYSTAL_OSCILLATOR     = 2'b00,
        UFR_CLK_RESERVED               = 2'b01,
        UFR_CLK_EXTERNAL_CLOCK_INPUT   = 2'b10,
        UFR_CLK_INTERNAL_RC_OSCILLATOR = 2'b11
    } ufr_clk_src_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] opcode;
        logic [7:0] addr;
        logic [7:0] data;
    } ufr_cmd_t;

    typedef struct packed {
        ufr_clk_src_t clk_src;
        logic [1:0]   startup_delay_select;
        logic [13:0]  startup_delay_us;
        logic         reset_pin_is_reset;
        logic         brownout_detector_en;
        logic         on_chip_debugger_en;
        logic         in_system_programming_en;
        logic [7:0]   rc_trim;
        logic         user_sig_write_en;
        logic         ports_start_tristate;
        logic         debug_if_fast;
    } ufr_cfg_t;

    localparam ufr_cfg_t CFG_RESET = '{
        clk_src:                  UFR_CLK_INTERNAL_RC_OSCILLATOR,
        startup_delay_select:     2'h3,
        startup_delay_us:         DELAY_OTHER_US_3,
        reset_pin_is_reset:       1'b1,
        brownout_detector_en:     1'b1,
        on_chip_debugger_en:      1'b0,
        in_system_programming_en: 1'b1,
        rc_trim:                  8'hFF,
        user_sig_write_en:        1'b0,
        ports_start_tristate:     1'b1,
        debug_if_fast:            1'b0
    };

endpackage

`default_nettype wire

// ---- rtl/ufr_fuse_row.sv ----
// User fuse row: storage of nineteen fuse bytes, the fuse commands of the
// programming path, and the registered configuration decoded from them.
// Assumes command, power-on and session-end inputs come from logic on
// ref_clk; rst_n stands for a blank (never programmed) fuse row.

`timescale 1ns/1ps
`default_nettype none

module ufr_fuse_row
    import ufr_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst_n,
    input  wire ufr_cmd_t cmd,
    input  wire logic     write_inhibit,
    input  wire logic     por_load,
    input  wire logic     por_active,
    input  wire logic     session_end,
    output logic [7:0]    rd_data_r,
    output logic          rd_valid_r,
    output logic          cmd_error_r,
    output ufr_cfg_t      cfg_r,
    output logic          cfg_pending,
    output logic          prog_permit
);

    //--------------------------------------------------------------------
    // Command decode
    //--------------------------------------------------------------------

    logic [7:0] fuse_r [FUSE_COUNT];
    logic [4:0] ptr_r;
    logic [4:0] ptr_nxt;
    logic [4:0] eff_addr;
    logic       addr_ok;
    logic       is_wr;
    logic       is_wr_ae;
    logic       is_rd;
    logic       do_write;
    logic       row_erase;

    // One flag per fuse: high while the stored byte is still all ones.
    logic [FUSE_COUNT-1:0] fuse_set;

    assign eff_addr = cmd.first ? cmd.addr[4:0] : ptr_r;
    assign addr_ok  = (!cmd.first || cmd.addr[7:5] == 3'h0)
                      && (eff_addr < 5'(FUSE_COUNT));
    assign is_wr    = cmd.valid && cmd.opcode == OP_FUSE_WRITE;
    assign is_wr_ae = cmd.valid && cmd.opcode == OP_FUSE_WRITE_AE;
    assign is_rd    = cmd.valid && cmd.opcode == OP_FUSE_READ;
    assign do_write = (is_wr || is_wr_ae) && addr_ok && !write_inhibit;
    // Only the first byte of an auto-erase write wipes the row, so the
    // following bytes of the same command land on freshly erased fuses.
    assign row_erase = is_wr_ae && cmd.first && !write_inhibit;
    assign ptr_nxt  = eff_addr + 5'h01;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ptr_r <= 5'h00;
        else if (cmd.valid)
            ptr_r <= ptr_nxt;
    end

    //--------------------------------------------------------------------
    // Fuse storage
    //--------------------------------------------------------------------

    genvar gi;
    generate
        for (gi = 0; gi < FUSE_COUNT; gi++)
        begin : g_fuse
            logic hit;
            assign hit = do_write && eff_addr == 5'(gi);
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    fuse_r[gi] <= FUSE_ERASED;
                else if (hit && row_erase)
                    fuse_r[gi] <= cmd.data;
                else if (hit)
                    fuse_r[gi] <= fuse_r[gi] & cmd.data;
                else if (row_erase)
                    fuse_r[gi] <= FUSE_ERASED;
            end
            // A byte left partly cleared counts as programmed, which turns the
            // debugger and signature write on but brown-out and programming off.
            assign fuse_set[gi] = (fuse_r[gi] == FUSE_ERASED);
        end
    endgenerate

    //--------------------------------------------------------------------
    // Read path and errors
    //--------------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_valid_r <= 1'b0;
        else
            rd_valid_r <= is_rd;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_r <= FUSE_ERASED;
        else if (is_rd)
            rd_data_r <= addr_ok ? fuse_r[eff_addr] : FUSE_ERASED;
    end

    // Unknown opcode or address beyond the row is flagged for one cycle.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_error_r <= 1'b0;
        else
            cmd_error_r <= cmd.valid && (!(is_wr || is_wr_ae || is_rd)
                                         || !addr_ok);
    end

    //--------------------------------------------------------------------
    // Configuration decode
    //--------------------------------------------------------------------

    ufr_clk_src_t fuse_src;
    ufr_clk_src_t load_src;
    logic [1:0]   delay_sel;
    logic [13:0]  delay_us;
    logic         pin_is_reset;
    logic         brownout_on;
    logic         debugger_on;
    logic         prog_on;
    logic [7:0]   trim;
    logic         sig_write_on;
    logic         ports_tristate;
    logic         debug_fast;
    ufr_cfg_t     dec;

    assign fuse_src = ufr_clk_src_t'({fuse_set[ADDR_CS1],
                                      fuse_set[ADDR_CS0]});

    assign load_src = por_load ? fuse_src : cfg_r.clk_src;

    //--------------------------------------------------------------------
    // Start-up delay
    //--------------------------------------------------------------------

    // The timeout follows the clock source that the load leaves active, so
    // a session end keeps the table of the source still in use.
    assign delay_sel = {fuse_set[ADDR_STARTUP1], fuse_set[ADDR_STARTUP0]};

    always_comb
    begin
        if (load_src == UFR_CLK_CRYSTAL_OSCILLATOR)
        begin
            case (delay_sel)
                2'h0:    delay_us = DELAY_CRYSTAL_US_0;
                2'h1:    delay_us = DELAY_CRYSTAL_US_1;
                2'h2:    delay_us = DELAY_CRYSTAL_US_2;
                default: delay_us = DELAY_CRYSTAL_US_3;
            endcase
        end
        else
        begin
            case (delay_sel)
                2'h0:    delay_us = DELAY_OTHER_US_0;
                2'h1:    delay_us = DELAY_OTHER_US_1;
                2'h2:    delay_us = DELAY_OTHER_US_2;
                default: delay_us = DELAY_OTHER_US_3;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Pin, debug and port functions
    //--------------------------------------------------------------------

    assign pin_is_reset   = fuse_set[ADDR_RST_PIN];
    assign brownout_on    = fuse_set[ADDR_BROWNOUT];
    assign debugger_on    = !fuse_set[ADDR_DEBUG];
    assign prog_on        = fuse_set[ADDR_PROG_EN];
    assign trim           = fuse_set[ADDR_TRIM_BASE +: 8];
    assign sig_write_on   = !fuse_set[ADDR_SIG];
    assign ports_tristate = fuse_set[ADDR_TRISTATE];
    assign debug_fast     = !fuse_set[ADDR_DEBUG_FAST];

    // Gathers the decoded fields in the layout of the active register.
    always_comb
    begin
        dec.clk_src                  = load_src;
        dec.startup_delay_select     = delay_sel;
        dec.startup_delay_us         = delay_us;
        dec.reset_pin_is_reset       = pin_is_reset;
        dec.brownout_detector_en     = brownout_on;
        dec.on_chip_debugger_en      = debugger_on;
        dec.in_system_programming_en = prog_on;
        dec.rc_trim                  = trim;
        dec.user_sig_write_en        = sig_write_on;
        dec.ports_start_tristate     = ports_tristate;
        dec.debug_if_fast            = debug_fast;
    end

    //--------------------------------------------------------------------
    // Active configuration
    //--------------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= CFG_RESET;
        else if (por_load || session_end)
            cfg_r <= dec;
    end

    assign cfg_pending = (fuse_src != cfg_r.clk_src) || (dec != cfg_r);

    assign prog_permit = cfg_r.in_system_programming_en || por_active;

endmodule

`default_nettype wire

// ---- tb/ufr_monitor.sv ----
// Port assertions for the user fuse row.
// Assumes a bind onto ufr_fuse_row; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ufr_monitor
    import ufr_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire ufr_cmd_t   cmd,
    input wire logic       por_load,
    input wire logic       por_active,
    input wire logic       session_end,
    input wire logic [7:0] rd_data_r,
    input wire logic       rd_valid_r,
    input wire logic       cmd_error_r,
    input wire ufr_cfg_t   cfg_r,
    input wire logic       cfg_pending,
    input wire logic       prog_permit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic rd_ok;
    logic bad;
    assign rd_ok = cmd.valid && cmd.first && cmd.opcode == OP_FUSE_READ;
    assign bad = cmd.valid && cmd.first && cmd.addr >= 8'h13;
    chk_read_answer: assert property (rd_ok && !bad |=> rd_valid_r)
        else $error("read got no answer");
    chk_bad_addr_rd: assert property (rd_ok && bad
        |=> rd_data_r == FUSE_ERASED && cmd_error_r)
        else $error("bad address read wrong");
    chk_good_no_err: assert property (!bad && cmd.valid && cmd.first
        && cmd.opcode == OP_FUSE_WRITE |=> !cmd_error_r)
        else $error("error on good address");
    chk_write_no_rd: assert property (cmd.valid
        && cmd.opcode != OP_FUSE_READ |=> !rd_valid_r)
        else $error("read pulse on write");
    chk_cfg_hold: assert property (!por_load && !session_end
        |=> $stable(cfg_r))
        else $error("config moved without event");
    chk_clk_kept: assert property (session_end && !por_load
        |=> $stable(cfg_r.clk_src))
        else $error("clock source changed at session end");
    chk_prog_permit: assert property (prog_permit
        == (cfg_r.in_system_programming_en | por_active))
        else $error("programming permit wrong");
    chk_por_settles: assert property (por_load && !cmd.valid
        |=> !cfg_pending)
        else $error("config pending after power-on load");
endmodule
`default_nettype wire

// ---- tb/ufr_prog_model.sv ----
// Programmer model: sends fuse command bytes, one per clock.
// Assumes the bench calls its tasks with bytes 00h or FFh only.
`timescale 1ns/1ps
`default_nettype none
module ufr_prog_model
    import ufr_pkg::*;
(
    input  wire logic    ref_clk,
    output var ufr_cmd_t cmd
);
    initial cmd = '0;
    task automatic put(input logic f, input logic [7:0] op,
                       input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cmd <= '{1'b1, f, op, a, d};
    endtask
    // Released lines show the inverse of the last byte.
    task automatic idle();
        @(posedge ref_clk);
        cmd <= '{1'b0, ~cmd.first, ~cmd.opcode, ~cmd.addr, ~cmd.data};
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the user fuse row.
// Assumes the package, design, programmer model and monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ufr_pkg::*;
;
    logic ref_clk, rst_n, write_inhibit, por_load, por_active;
    logic session_end, rd_valid_r, cmd_error_r, cfg_pending, prog_permit;
    logic [7:0] rd_data_r;
    ufr_cmd_t cmd;
    ufr_cfg_t cfg_r, exp_cfg;
    int error_cnt, n_checks;
    ufr_fuse_row ufr_fuse_row_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd(cmd), .write_inhibit(write_inhibit), .por_load(por_load),
        .por_active(por_active), .session_end(session_end),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .cmd_error_r(cmd_error_r), .cfg_r(cfg_r),
        .cfg_pending(cfg_pending), .prog_permit(prog_permit));
    ufr_prog_model prog_inst (.ref_clk(ref_clk), .cmd(cmd));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic pulse(input int sel);
        @(posedge ref_clk);
        por_load <= (sel == 0);
        session_end <= (sel == 1);
        @(posedge ref_clk);
        por_load <= 1'b0;
        session_end <= 1'b0;
        #1;
    endtask
    task automatic rd_run(input logic [4:0] a, input int n,
                          input logic [7:0] e);
        for (int i = 0; i <= n; i++)
        begin
            if (i < n)
                prog_inst.put(i == 0, OP_FUSE_READ, {3'h0, a}, 8'h00);
            else
                prog_inst.idle();
            #1;
            if (i > 0)
            begin
                chk(rd_data_r, e);
                chk(rd_valid_r, 1'b1);
            end
        end
    endtask
    function automatic logic [7:0] fv(input int i, input int j);
        if (j < 4)
            return i[j % 2] ? 8'hFF : 8'h00;
        return (j == 8) ? 8'h00 : 8'hFF;
    endfunction
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        logic [13:0] d;
        {rst_n, write_inhibit, por_load, por_active, session_end} = '0;
        error_cnt = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk(cfg_r, CFG_RESET);
        rd_run(5'h00, 19, 8'hFF);
        rd_run(5'h13, 1, 8'hFF);
        chk(cmd_error_r, 1'b1);
        $display("test blank row done");
        prog_inst.put(1, OP_FUSE_WRITE, 8'h04, 8'h00);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h05, 8'hFF);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h06, 8'h00);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h07, 8'h00);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h08, 8'h00);
        write_inhibit <= 1'b1;
        prog_inst.idle();
        write_inhibit <= 1'b0;
        rd_run(5'h04, 1, 8'h00);
        rd_run(5'h05, 1, 8'hFF);
        rd_run(5'h08, 1, 8'hFF);
        chk(cfg_r, CFG_RESET);
        chk(cfg_pending, 1'b1);
        pulse(1);
        exp_cfg = CFG_RESET;
        exp_cfg.reset_pin_is_reset = 1'b0;
        exp_cfg.on_chip_debugger_en = 1'b1;
        exp_cfg.in_system_programming_en = 1'b0;
        chk(cfg_r, exp_cfg);
        chk(prog_permit, 1'b0);
        @(posedge ref_clk);
        por_active <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(prog_permit, 1'b1);
        @(posedge ref_clk);
        por_active <= 1'b0;
        $display("test plain writes done");
        for (int i = 0; i < 4; i++)
        begin
            for (int j = 0; j < 9; j++)
                prog_inst.put(j == 0, OP_FUSE_WRITE_AE, 8'h00, fv(i, j));
            prog_inst.idle();
            pulse(0);
            d = (i == 0) ? DELAY_CRYSTAL_US_0 :
                ((i == 2) ? DELAY_OTHER_US_2 : DELAY_OTHER_US_3);
            chk(cfg_r.clk_src, i);
            if (i != 1)
                chk(cfg_r.startup_delay_us, d);
            chk(cfg_r.startup_delay_select, i);
            chk(cfg_r.rc_trim, 8'hFE);
            chk(cfg_r.reset_pin_is_reset, 1'b1);
            chk(cfg_r.brownout_detector_en, 1'b1);
        end
        $display("test clock sources done");
        prog_inst.put(1, OP_FUSE_WRITE, 8'h00, 8'h00);
        prog_inst.put(1, OP_FUSE_WRITE, 8'h10, 8'h00);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h11, 8'h00);
        prog_inst.put(0, OP_FUSE_WRITE, 8'h12, 8'h00);
        prog_inst.idle();
        rd_run(5'h00, 1, 8'h00);
        pulse(1);
        chk(cfg_r.clk_src, UFR_CLK_INTERNAL_RC_OSCILLATOR);
        chk(cfg_r.user_sig_write_en, 1'b1);
        chk(cfg_r.ports_start_tristate, 1'b0);
        chk(cfg_r.debug_if_fast, 1'b1);
        chk(cfg_pending, 1'b1);
        pulse(0);
        chk(cfg_r.clk_src, UFR_CLK_EXTERNAL_CLOCK_INPUT);
        chk(cfg_pending, 1'b0);
        $display("test late fuses done");
        wrap_up();
    end
endmodule
bind ufr_fuse_row ufr_monitor ufr_monitor_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .cmd(cmd), .por_load(por_load),
    .por_active(por_active), .session_end(session_end),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .cmd_error_r(cmd_error_r), .cfg_r(cfg_r),
    .cfg_pending(cfg_pending), .prog_permit(prog_permit));
`default_nettype wire
